// ===== verilog/nfh_map.vh
`ifndef NFH_MAP_VH
`define NFH_MAP_VH
// Command codes
`define NFH_CMD_READ_1     8'h00
`define NFH_CMD_READ_2     8'h30
// Array geometry
`define NFH_BLOCKS         1024
`define NFH_PAGES_PER_BLK  64
`define NFH_MAIN_BYTES     2048
`define NFH_SPARE_BYTES    64
`define NFH_PAGE_BYTES     2112
`define NFH_COL_BITS       12
`define NFH_ROW_BITS       16
// Timing in ns and cycles at 4 ns
`define NFH_CLK_NS         4
`define NFH_WE_LOW_NS      12
`define NFH_WE_LOW_CYC     ((`NFH_WE_LOW_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_RD_ACCESS_NS   20
`define NFH_RD_ACCESS_CYC  ((`NFH_RD_ACCESS_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_BUSY_WAIT_NS   100
`define NFH_BUSY_WAIT_CYC  ((`NFH_BUSY_WAIT_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`endif

// ===== verilog/nfh_fifo.v
`timescale 1ns/100ps
`default_nettype none
// Synchronous FIFO with valid/ready on both sides
module nfh_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clock_i,
   input  wire             rst_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;
   assign in_ready_o  = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   // Storage write
   always @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
   // Pointers and fill level
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verilog/nfh_host.v
`timescale 1ns/100ps
`default_nettype none
`include "nfh_map.vh"
module nfh_host #(
   parameter COL_W = `NFH_COL_BITS,
   parameter ROW_W = `NFH_ROW_BITS,
   parameter DEPTH = 16
) (
   // Clock and reset
   input  wire             clock_i,
   input  wire             rst_i,
   // Request side
   input  wire             req_valid_i,
   output wire             req_ready_o,
   input  wire [COL_W-1:0] req_col_i,
   input  wire [ROW_W-1:0] req_row_i,
   input  wire [COL_W:0]   req_len_i,
   input  wire             prot_i,
   // Read data stream
   output wire [7:0]       rd_data_o,
   output wire             rd_valid_o,
   input  wire             rd_ready_i,
   output wire             busy_o,
   // Flash pins
   output reg              chip_en_n_o,
   output reg              cmd_sel_o,
   output reg              addr_sel_o,
   output reg              write_strobe_n_o,
   output reg              read_strobe_n_o,
   output reg              write_prot_n_o,
   input  wire [7:0]       io_i,
   output reg  [7:0]       io_o,
   output reg              io_oe_n_o,
   input  wire             ready_busy_n_i
);
   // ************************************************************
   // State machine
   // ************************************************************
   localparam ST_IDLE  = 3'h0;
   localparam ST_CMD1  = 3'h1;
   localparam ST_ADDR  = 3'h2;
   localparam ST_CMD2  = 3'h3;
   localparam ST_WAIT  = 3'h4;
   localparam ST_READ  = 3'h5;
   localparam ST_DONE  = 3'h6;
   localparam WE_CYC   = `NFH_WE_LOW_CYC;
   localparam RD_CYC   = `NFH_RD_ACCESS_CYC;
   localparam BW_CYC   = `NFH_BUSY_WAIT_CYC;

   reg  [2:0]       state;
   reg  [7:0]       timer;
   reg  [1:0]       phase;
   reg  [1:0]       addr_idx;
   reg  [COL_W:0]   remain;
   reg  [COL_W-1:0] col;
   reg  [ROW_W-1:0] row;
   reg  [7:0]       cap_data;
   reg              cap_valid;
   wire             fifo_ready;
   reg  [7:0]       addr_byte;

   assign req_ready_o = (state == ST_IDLE);
   assign busy_o      = (state != ST_IDLE);

   // Address byte order: column low, column high, row low, row high
   always @* begin
      case (addr_idx)
         2'h0:    addr_byte = col[7:0];
         2'h1:    addr_byte = {4'h0, col[COL_W-1:8]};
         2'h2:    addr_byte = row[7:0];
         default: addr_byte = row[ROW_W-1:8];
      endcase
   end

   // Sequencer: write strobe low for WE_CYC, read strobe low for RD_CYC, both high for WE_CYC
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state            <= ST_IDLE;
         timer            <= 8'h00;
         phase            <= 2'h0;
         addr_idx         <= 2'h0;
         remain           <= {(COL_W+1){1'b0}};
         col              <= {COL_W{1'b0}};
         row              <= {ROW_W{1'b0}};
         cap_data         <= 8'h00;
         cap_valid        <= 1'b0;
         chip_en_n_o      <= 1'b1;
         cmd_sel_o        <= 1'b0;
         addr_sel_o       <= 1'b0;
         write_strobe_n_o <= 1'b1;
         read_strobe_n_o  <= 1'b1;
         write_prot_n_o   <= 1'b0;
         io_o             <= 8'h00;
         io_oe_n_o        <= 1'b1;
      end else begin
         cap_valid      <= 1'b0;
         write_prot_n_o <= ~prot_i;
         if (timer != 8'h00) begin
            timer <= timer - 8'h01;
         end else begin
            case (state)
               ST_IDLE: begin
                  chip_en_n_o <= 1'b1;
                  io_oe_n_o   <= 1'b1;
                  if (req_valid_i) begin
                     col         <= req_col_i;
                     row         <= req_row_i;
                     remain      <= req_len_i;
                     chip_en_n_o <= 1'b0;
                     state       <= ST_CMD1;
                     phase       <= 2'h0;
                  end
               end
               ST_CMD1, ST_CMD2, ST_ADDR: begin
                  if (phase == 2'h0) begin
                     // Set up selects and drive the byte, strobe low
                     cmd_sel_o        <= (state != ST_ADDR);
                     addr_sel_o       <= (state == ST_ADDR);
                     io_o             <= (state == ST_CMD1) ? `NFH_CMD_READ_1 :
                                         (state == ST_CMD2) ? `NFH_CMD_READ_2 :
                                         addr_byte;
                     io_oe_n_o        <= 1'b0;
                     write_strobe_n_o <= 1'b0;
                     timer            <= WE_CYC[7:0] - 8'h01;
                     phase            <= 2'h1;
                  end else begin
                     // Rising edge latches the byte, data still held
                     write_strobe_n_o <= 1'b1;
                     timer            <= WE_CYC[7:0] - 8'h01;
                     phase            <= 2'h0;
                     if (state == ST_CMD1) begin
                        state    <= ST_ADDR;
                        addr_idx <= 2'h0;
                     end else if (state == ST_ADDR) begin
                        addr_idx <= addr_idx + 2'h1;
                        if (addr_idx == 2'h3) begin
                           state <= ST_CMD2;
                        end
                     end else begin
                        state <= ST_WAIT;
                        timer <= BW_CYC[7:0] - 8'h01;
                     end
                  end
               end
               ST_WAIT: begin
                  cmd_sel_o  <= 1'b0;
                  addr_sel_o <= 1'b0;
                  io_oe_n_o  <= 1'b1;
                  // Busy low while the page moves to the data register
                  if (ready_busy_n_i) begin
                     state <= (remain == {(COL_W+1){1'b0}}) ? ST_DONE : ST_READ;
                     phase <= 2'h0;
                  end
               end
               ST_READ: begin
                  if (phase == 2'h0) begin
                     // Stall here while the FIFO is full
                     if (fifo_ready) begin
                        read_strobe_n_o <= 1'b0;
                        timer           <= RD_CYC[7:0] - 8'h01;
                        phase           <= 2'h1;
                     end
                  end else begin
                     // Byte valid after the access delay, take it
                     cap_data        <= io_i;
                     cap_valid       <= 1'b1;
                     read_strobe_n_o <= 1'b1;
                     col             <= col + 1'b1;
                     remain          <= remain - 1'b1;
                     timer           <= WE_CYC[7:0] - 8'h01;
                     phase           <= 2'h0;
                     if (remain == {{COL_W{1'b0}}, 1'b1}) begin
                        state <= ST_DONE;
                     end
                  end
               end
               ST_DONE: begin
                  chip_en_n_o <= 1'b1;
                  state       <= ST_IDLE;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Read data buffer
   // ************************************************************
   nfh_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH),
      .AW    (4)
   ) u_fifo (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .in_data_i   (cap_data),
      .in_valid_i  (cap_valid),
      .in_ready_o  (fifo_ready),
      .out_data_o  (rd_data_o),
      .out_valid_o (rd_valid_o),
      .out_ready_i (rd_ready_i)
   );
endmodule
`default_nettype wire

// ===== sim/nfh_host_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module nfh_host_chk (
   // Clock and reset
   input wire logic       clock_i,
   input wire logic       rst_i,
   // Watched ports
   input wire logic       req_ready_o,
   input wire logic       prot_i,
   input wire logic       chip_en_n_o,
   input wire logic       cmd_sel_o,
   input wire logic       addr_sel_o,
   input wire logic       write_strobe_n_o,
   input wire logic       read_strobe_n_o,
   input wire logic       write_prot_n_o,
   input wire logic [7:0] io_o,
   input wire logic       io_oe_n_o,
   input wire logic       ready_busy_n_i
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_sel_excl: assert property (!(cmd_sel_o && addr_sel_o))
      else $error("both latch selects high");
   a_strobe_excl: assert property (!(!write_strobe_n_o && !read_strobe_n_o))
      else $error("both strobes low");
   a_write_drives: assert property (!write_strobe_n_o |-> !io_oe_n_o && !chip_en_n_o)
      else $error("write strobe without bus drive");
   a_read_floats: assert property (!read_strobe_n_o |-> io_oe_n_o)
      else $error("bus driven during read");
   a_we_width: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o [*3])
      else $error("write strobe low too short");
   a_latch_hold: assert property ($rose(write_strobe_n_o) |-> $stable(io_o)
      && $stable(cmd_sel_o) && $stable(addr_sel_o)) else $error("bus moved at latch");
   a_no_rd_busy: assert property (!ready_busy_n_i |-> read_strobe_n_o)
      else $error("read while busy");
   a_re_width: assert property ($fell(read_strobe_n_o) |-> !read_strobe_n_o [*5])
      else $error("read strobe low too short");
   a_idle_ce: assert property (req_ready_o |-> chip_en_n_o)
      else $error("chip enabled while idle");
   a_prot_wp: assert property (prot_i |=> !write_prot_n_o)
      else $error("write protect not low");
endmodule
bind nfh_host nfh_host_chk u_chk (.clock_i, .rst_i, .req_ready_o, .prot_i, .chip_en_n_o,
   .cmd_sel_o, .addr_sel_o, .write_strobe_n_o, .read_strobe_n_o, .write_prot_n_o, .io_o,
   .io_oe_n_o, .ready_busy_n_i);
`default_nettype wire

// ===== sim/nfh_flash_mdl.sv
`timescale 1ns/100ps
`default_nettype none
module nfh_flash_mdl #(
   parameter BUSY_NS = 400,
   parameter RD_NS   = 16
) (
   // Strobes and bus
   input wire logic       chip_en_n_i,
   input wire logic       cmd_sel_i,
   input wire logic       addr_sel_i,
   input wire logic       write_strobe_n_i,
   input wire logic       read_strobe_n_i,
   input wire logic [7:0] bus_i,
   output logic     [7:0] bus_o,
   output logic           busy_pull_o
);
   logic [7:0]  cmd1, cmd2, ab0, ab1, ab2, ab3;
   logic [11:0] col;
   logic [15:0] row;
   integer      na = 0, n_rd = 0, n_busy = 0;
   initial bus_o = 8'h5A;
   initial busy_pull_o = 1'b0;
   // Latch on write strobe rise; deselected means ignored; no program, so never unprotected
   always @(posedge write_strobe_n_i) if (!chip_en_n_i) begin
      if (cmd_sel_i && bus_i == 8'h00) begin
         cmd1 = bus_i; na = 0; n_rd = 0;
      end else if (cmd_sel_i) begin
         cmd2 = bus_i;
         col = {ab1[3:0], ab0};
         row = {ab3, ab2}; // Block in upper 10 bits, page in lower 6
         busy_pull_o = 1'b1; // Pull low only
         n_busy = n_busy + 1;
         #(BUSY_NS) busy_pull_o = 1'b0;
      end else if (addr_sel_i) begin
         case (na) 0: ab0 = bus_i; 1: ab1 = bus_i; 2: ab2 = bus_i; default: ab3 = bus_i; endcase
         na = na + 1;
      end
   end
   // Data valid after access delay; garbage before and after
   always @(negedge read_strobe_n_i) if (!chip_en_n_i && !busy_pull_o) begin
      bus_o = ~bus_o;
      #(RD_NS) bus_o = col[7:0] ^ row[7:0];
   end
   // Column advances per pulse, wraps at page end
   always @(posedge read_strobe_n_i) if (!chip_en_n_i) begin
      col = (col == 12'd2111) ? 12'h000 : col + 12'h001;
      n_rd = n_rd + 1;
      bus_o = ~bus_o;
   end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clock_i = 0, rst_i = 1, req_valid_i = 0, rd_ready_i = 0, prot_i = 0;
   logic [11:0] req_col_i = 0;
   logic [15:0] req_row_i = 0;
   logic [12:0] req_len_i = 0;
   wire         req_ready_o, rd_valid_o, busy_o, chip_en_n_o, cmd_sel_o, addr_sel_o;
   wire         write_strobe_n_o, read_strobe_n_o, write_prot_n_o, io_oe_n_o, fl_pull;
   wire  [7:0]  rd_data_o, io_o, fl_bus;
   integer      err_total = 0, n_checks = 0, nreq = 0;
   // Shared bus and pulled-up ready line
   wire [7:0] io_i = io_oe_n_o ? fl_bus : io_o;
   wire ready_busy_n_i = ~fl_pull;
   always #2 clock_i = ~clock_i;
   nfh_host dut (.clock_i, .rst_i, .req_valid_i, .req_ready_o, .req_col_i, .req_row_i,
      .req_len_i, .prot_i, .rd_data_o, .rd_valid_o, .rd_ready_i, .busy_o, .chip_en_n_o,
      .cmd_sel_o, .addr_sel_o, .write_strobe_n_o, .read_strobe_n_o, .write_prot_n_o,
      .io_i, .io_o, .io_oe_n_o, .ready_busy_n_i);
   nfh_flash_mdl mdl (.chip_en_n_i(chip_en_n_o), .cmd_sel_i(cmd_sel_o),
      .addr_sel_i(addr_sel_o), .write_strobe_n_i(write_strobe_n_o),
      .read_strobe_n_i(read_strobe_n_o), .bus_i(io_i), .bus_o(fl_bus), .busy_pull_o(fl_pull));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Page read of n bytes; stall holds the consumer off first
   task do_read(input logic [11:0] c, input logic [15:0] r, input logic [12:0] n,
                input integer stall);
      integer k, t;
      logic [11:0] cc;
      @(negedge clock_i);
      req_col_i = c; req_row_i = r; req_len_i = n; req_valid_i = 1;
      t = 0;
      // Ready is judged at the falling edge, away from the edge that changes it
      while (req_ready_o !== 1'b1 && t < 100) begin
         @(negedge clock_i);
         t = t + 1;
      end
      // One rising edge with ready high takes the request
      @(negedge clock_i);
      req_valid_i = 0;
      nreq = nreq + 1;
      if (t >= 100) err_total = err_total + 1;
      chk(req_ready_o, 16'h0000);
      if (stall > 0) begin
         repeat (stall) @(negedge clock_i);
         chk(mdl.n_rd, 16'h0010);
      end
      rd_ready_i = 1;
      k = 0; t = 0;
      // Head byte is judged at the falling edge before the rising edge that pops it
      while (k < n && t < 20000) begin
         cc = c + k[11:0];
         if (rd_valid_o === 1'b1) begin
            chk(rd_data_o, {8'h00, cc[7:0] ^ r[7:0]});
            k = k + 1;
         end
         @(negedge clock_i);
         t = t + 1;
      end
      t = 0;
      while (busy_o !== 1'b0 && t < 1000) begin
         @(negedge clock_i);
         t = t + 1;
      end
      rd_ready_i = 0;
      chk(busy_o, 16'h0000);
      chk(k, n);
      chk(chip_en_n_o, 16'h0001);
      chk({mdl.cmd1, mdl.cmd2}, 16'h0030);
      chk({mdl.ab1[7:4], mdl.col}, {4'h0, c + n[11:0]});
      chk(mdl.row, r);
      chk(mdl.n_busy, nreq);
   endtask
   // Write protect follows the level one cycle later
   task t_prot;
      @(negedge clock_i); prot_i = 1;
      @(negedge clock_i); chk(write_prot_n_o, 16'h0000);
      prot_i = 0;
      repeat (2) @(negedge clock_i);
      chk(write_prot_n_o, 16'h0001);
   endtask
   initial begin
      repeat (20) @(negedge clock_i);
      chk({chip_en_n_o, write_prot_n_o, io_oe_n_o}, 16'h0005);
      rst_i = 0;
      t_prot;
      do_read(12'h7FE, 16'hABCD, 13'd4, 0);
      do_read(12'h010, 16'h0041, 13'd0, 0);
      do_read(12'h000, 16'hFFFF, 13'd20, 500);
      finish_test;
   end
   // Watchdog
   initial begin
      #200000;
      err_total = err_total + 1;
      finish_test;
   end
endmodule
`default_nettype wire
